// ===== design/wcc_pkg.sv
// constants, types and register map of the weight channel conditioner
package wcc_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_NS = 10;
	localparam int unsigned TICK_NS = 10_000;
	localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
	localparam int unsigned TICKS_PER_S = 1_000_000_000 / TICK_NS;
	localparam int unsigned RATE_CHZ [8] = '{230, 460, 930, 1900, 3700, 7500, 15000, 30000};
	localparam int unsigned MOTION_MIN_MS = 200;
	localparam logic [15:0] MOTION_MIN_TICKS = 16'(MOTION_MIN_MS * TICKS_PER_S / 1000);
	localparam logic [31:0] TICKS_PER_DS = 32'(TICKS_PER_S / 10);
	localparam logic [31:0] TICKS_PER_CS = 32'(TICKS_PER_S / 100);
	localparam logic [31:0] AUTO_DERIV_CS = 32'h00000064;
	localparam logic [31:0] FLOW_SCALE = 32'h000186A0;
	localparam logic [31:0] MUL_MIN = 32'h0000003C;
	localparam logic [31:0] MUL_HOUR = 32'h00000E10;
	localparam logic [31:0] DIV_KILO = 32'h000003E8;
	localparam logic [31:0] UNDER_STEPS = 32'h00000009;
	localparam logic [31:0] ZT_MAX_STEPS = 32'h0000001E;
	localparam logic [31:0] AZ_STEPS = 32'h00000004;
	localparam logic [6:0] DIV_BITS = 7'h40;
	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00, A_RES = 8'h04, A_CAP = 8'h08, A_OLIM = 8'h0C;
	localparam logic [7:0] A_FWIN = 8'h10, A_MWIN = 8'h14, A_NMDLY = 8'h18, A_ZTRATE = 8'h1C;
	localparam logic [7:0] A_PTARE = 8'h20, A_DERIV = 8'h24, A_FRES = 8'h28, A_CONV = 8'h2C;
	localparam logic [7:0] A_CALT = 8'h30, A_ZOFF = 8'h34, A_STAT = 8'h38, A_GROSS = 8'h3C;
	localparam logic [7:0] A_NET = 8'h40, A_FLOW = 8'h44;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {OL_OFF = 2'b00, OL_UNI = 2'b01, OL_BI = 2'b10} wcc_ol_e;
	typedef enum logic [1:0] {ZT_OFF = 2'b00, ZT_TRACK = 2'b01, ZT_TRACK_AUTO = 2'b10} wcc_zt_e;
	typedef enum logic [1:0] {TM_AUTO = 2'b00, TM_PRESET = 2'b01, TM_SUM = 2'b10} wcc_tare_e;
	typedef enum logic [2:0] {FU_SEC = 3'b000, FU_MIN = 3'b001, FU_HOUR = 3'b010,
		FU_KMIN = 3'b011, FU_KHOUR = 3'b100} wcc_fu_e;
	typedef enum logic [1:0] {CAL_SHEET = 2'b00, CAL_DEAD = 2'b01, CAL_TABLE = 2'b10} wcc_cal_e;
	typedef enum logic [1:0] {DV_IDLE = 2'b00, DV_RATE = 2'b01, DV_QUANT = 2'b10} wcc_div_e;
	typedef struct packed {
		logic [16:0] rsv;
		wcc_fu_e flow_unit;
		logic auto_deriv;
		logic flow_on;
		logic motion_check;
		wcc_tare_e tare_mode;
		wcc_zt_e zt_mode;
		wcc_ol_e ol_mode;
		logic [2:0] rate;
	} wcc_ctrl_s;
	typedef struct packed {
		logic flow_on;
		logic print_blk;
		logic tare_blk;
		logic zero_blk;
		logic underload;
		logic overload;
		logic motion;
	} wcc_status_s;
	typedef struct packed {
		logic signed [31:0] gross;
		logic signed [31:0] net;
		logic signed [31:0] flow;
	} wcc_weights_s;
	localparam wcc_ctrl_s CTRL_RST = '{rsv: 17'h00000, flow_unit: FU_SEC, auto_deriv: 1'b1,
		flow_on: 1'b1, motion_check: 1'b0, tare_mode: TM_AUTO, zt_mode: ZT_OFF,
		ol_mode: OL_OFF, rate: 3'h4};
	localparam logic [31:0] RES_RST = 32'h0000000A, CAP_RST = 32'h0000C350;
	localparam logic [31:0] FWIN_RST = 32'h00000064, MWIN_RST = 32'h0000000A;
	localparam logic [31:0] NMDLY_RST = 32'h0000000A, ZTRATE_RST = 32'h00000064;
	localparam logic [31:0] FRES_RST = 32'h00000014, CONV_RST = 32'h0009CE81;
	localparam logic [31:0] DERIV_RST = 32'h00000064;
endpackage : wcc_pkg

// ===== design/wcc_conditioner.sv
// weight channel conditioner: rate, filter, motion, overload, zero, tare, flow
// Behaviour
// - conversions started at one of eight rates, 37 Hz after reset
// - filtered weight used while filtered/unfiltered difference is below filter window
// - windows held in fine units, a tenth of a resolution step
// - motion when change over period exceeds motion window; period at least 200 ms
// - motion clears only after stable weight for the no-motion delay
// - zeroing always blocked in motion; tare and print too with motion check on
// - overload check off reports weight unbounded, no flags
// - unipolar: overload above limit, underload below minus nine steps
// - bipolar: flags at plus/minus limit, reported weight clamped to them
// - writing resolution or capacity resets limit to capacity plus nine steps
// - zero tracking off, tracking only, or tracking plus auto zeroing
// - tracking only under slow drift, rate capped below thirty steps
// - net is gross minus auto, preset or summed tare
// - flow computed only while flow calculation is enabled
// - flow is weight change over derivation time divided by that time
// - auto derivation fixes the time and makes its register read-only
// - flow scaled per second, minute, hour, or thousands per minute/hour
// - flow quantised to the flow resolution step, default 0.02
// - writing a calibration type starts a new calibration
// - zeroing offset is stored in an editable register applied directly
// - data-sheet samples scaled by conversion factor, default 9.80665
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module wcc_conditioner
	import wcc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic adc_valid,
	input wire logic signed [31:0] adc_data,
	output logic adc_start,
	input wire logic zero_req,
	input wire logic tare_req,
	input wire logic print_req,
	output logic print_ack,
	output logic cal_start,
	output wcc_weights_s weights,
	output wcc_status_s status
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		wcc_ctrl_s ctrl;
		logic [31:0] res, cap, ol_lim, fwin, mwin, nm_dly, zt_rate, ptare, deriv, fres, conv;
		wcc_cal_e cal_type;
		logic signed [31:0] zoff, filt, gross, net, prev_w, auto_tare, der_base, flow;
		logic [31:0] rdata, nm_cnt, der_cnt;
		logic [9:0] tick_cnt;
		logic [15:0] upd_cnt, per_cnt;
		logic adc_start, motion, over, under, print_ack, cal_start, flow_neg;
		wcc_div_e div_st;
		logic [63:0] num, den, rem;
		logic [6:0] div_cnt;
	} wcc_state_s;
	wcc_state_s st, next_st;
	logic [1:0] rst_sync;
	logic rst_n_int;
	logic [15:0] upd_tab [8];
	// release reset through two flops so every flop leaves reset on the same edge
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n_int = rst_sync[1];
	// update period per rate index, in 10 us ticks, rounded down
	for (genvar gi = 0; gi < 8; gi++)
	begin : g_rate
		assign upd_tab[gi] = 16'(TICKS_PER_S * 100 / RATE_CHZ[gi]);
	end
	// ------------------------------------------------------------
	// combinational helpers
	// ------------------------------------------------------------
	logic wr, rd_setup, tick, upd_end, per_end, der_end, mot_cond, near_zero, zt_ok;
	logic [15:0] upd_len, per_len;
	logic signed [63:0] prod;
	logic signed [31:0] scaled, g_raw, g_clamp, filt_nx, diff, chosen, dchg, tare, lim_neg;
	logic [31:0] absd, absc, zt_eff, deriv_eff, fmul, fdiv;
	always_comb
	begin
		wr = psel && penable && pwrite;
		rd_setup = psel && !penable;
		tick = st.tick_cnt == 10'(TICK_CYC - 1);
		upd_len = upd_tab[st.ctrl.rate];
		upd_end = tick && st.upd_cnt == 16'h0000;
		// a fast rate would make the motion period too short to see slow creep
		per_len = (upd_len < MOTION_MIN_TICKS) ? MOTION_MIN_TICKS : upd_len;
		per_end = tick && st.per_cnt == 16'h0000;
		prod = $signed(adc_data) * $signed(st.conv);
		scaled = (st.cal_type == CAL_SHEET) ? 32'(prod >>> 16) : adc_data;
		g_raw = scaled - st.zoff;
		lim_neg = -$signed(st.ol_lim);
		g_clamp = g_raw;
		if (st.ctrl.ol_mode == OL_BI && g_raw > $signed(st.ol_lim))
			g_clamp = $signed(st.ol_lim);
		else if (st.ctrl.ol_mode == OL_BI && g_raw < lim_neg)
			g_clamp = lim_neg;
		filt_nx = st.filt + ((g_clamp - st.filt) >>> 3);
		diff = filt_nx - g_clamp;
		absd = diff[31] ? 32'(-diff) : diff;
		// windows and weights share the fine unit, so a window finer than a step works
		chosen = (absd < st.fwin) ? filt_nx : g_clamp;
		dchg = st.gross - st.prev_w;
		absc = dchg[31] ? 32'(-dchg) : dchg;
		mot_cond = absc > st.mwin;
		zt_eff = (st.zt_rate < ZT_MAX_STEPS * st.res) ? st.zt_rate
			: 32'(ZT_MAX_STEPS * st.res - 32'h1);
		near_zero = (st.gross[31] ? 32'(-st.gross) : st.gross) <=
			((st.ctrl.zt_mode == ZT_TRACK_AUTO) ? 32'(AZ_STEPS * st.res) : (st.res >> 1));
		zt_ok = st.ctrl.zt_mode != ZT_OFF && !st.motion && !mot_cond && absc <= zt_eff
			&& near_zero;
		case (st.ctrl.tare_mode)
			TM_AUTO: tare = st.auto_tare;
			TM_PRESET: tare = st.ptare;
			TM_SUM: tare = st.auto_tare + st.ptare;
			default: tare = st.auto_tare;
		endcase
		deriv_eff = st.ctrl.auto_deriv ? AUTO_DERIV_CS : st.deriv;
		der_end = tick && st.der_cnt == 32'h0;
		case (st.ctrl.flow_unit)
			FU_SEC: begin fmul = 32'h1; fdiv = 32'h1; end
			FU_MIN: begin fmul = MUL_MIN; fdiv = 32'h1; end
			FU_HOUR: begin fmul = MUL_HOUR; fdiv = 32'h1; end
			FU_KMIN: begin fmul = MUL_MIN; fdiv = DIV_KILO; end
			FU_KHOUR: begin fmul = MUL_HOUR; fdiv = DIV_KILO; end
			default: begin fmul = 32'h1; fdiv = 32'h1; end
		endcase
	end
	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic [64:0] rem_sh;
	logic signed [31:0] dflow;
	always_comb
	begin
		next_st = st;
		rem_sh = 65'h0;
		dflow = 32'sh0;
		next_st.print_ack = 1'b0;
		next_st.cal_start = 1'b0;
		next_st.adc_start = 1'b0;
		// timebase and conversion start at the selected update rate
		next_st.tick_cnt = tick ? 10'h000 : st.tick_cnt + 10'h001;
		if (tick)
		begin
			next_st.upd_cnt = upd_end ? upd_len - 16'h1 : st.upd_cnt - 16'h1;
			next_st.per_cnt = per_end ? per_len - 16'h1 : st.per_cnt - 16'h1;
		end
		next_st.adc_start = upd_end;
		// each sample: scale, zero, clamp, filter and pick the reported weight
		if (adc_valid)
		begin
			next_st.filt = filt_nx;
			next_st.gross = chosen;
		end
		next_st.net = st.gross - tare;
		// overload check follows the reported gross one cycle later
		case (st.ctrl.ol_mode)
			OL_UNI:
			begin
				next_st.over = st.gross > $signed(st.ol_lim);
				next_st.under = st.gross < -$signed(32'(UNDER_STEPS * st.res));
			end
			OL_BI:
			begin
				next_st.over = st.gross >= $signed(st.ol_lim);
				next_st.under = st.gross <= lim_neg;
			end
			default:
			begin
				next_st.over = 1'b0;
				next_st.under = 1'b0;
			end
		endcase
		// motion: set at once, clear after a full stable delay
		if (per_end)
		begin
			next_st.prev_w = st.gross;
			if (mot_cond)
			begin
				next_st.motion = 1'b1;
				next_st.nm_cnt = 32'(st.nm_dly * TICKS_PER_DS);
			end
			else if (zt_ok)
				next_st.zoff = st.zoff + st.gross;
		end
		if (tick && st.motion && !(per_end && mot_cond))
		begin
			if (st.nm_cnt == 32'h0)
				next_st.motion = 1'b0;
			else
				next_st.nm_cnt = st.nm_cnt - 32'h1;
		end
		// operator requests, blocked during motion as configured
		if (zero_req && !st.motion)
			next_st.zoff = st.zoff + st.gross;
		if (tare_req && !(st.motion && st.ctrl.motion_check))
			next_st.auto_tare = st.gross;
		next_st.print_ack = print_req && !(st.motion && st.ctrl.motion_check);
		// flow window and divider; two passes: rate, then quantise
		if (!st.ctrl.flow_on)
		begin
			next_st.div_st = DV_IDLE;
			next_st.der_cnt = 32'(deriv_eff * TICKS_PER_CS);
			next_st.der_base = st.gross;
		end
		else
		begin
			if (tick)
				next_st.der_cnt = der_end ? 32'(deriv_eff * TICKS_PER_CS) - 32'h1
					: st.der_cnt - 32'h1;
			case (st.div_st)
				DV_IDLE:
					if (der_end && deriv_eff != 32'h0 && st.fres != 32'h0)
					begin
						dflow = st.gross - st.der_base;
						next_st.der_base = st.gross;
						next_st.flow_neg = dflow[31];
						next_st.num = 64'(dflow[31] ? 32'(-dflow) : dflow) * 64'(FLOW_SCALE)
							* 64'(fmul);
						next_st.den = 64'(deriv_eff) * 64'(fdiv);
						next_st.rem = 64'h0;
						next_st.div_cnt = DIV_BITS;
						next_st.div_st = DV_RATE;
					end
				DV_RATE, DV_QUANT:
				begin
					rem_sh = {st.rem, st.num[63]};
					if (rem_sh >= {1'b0, st.den})
					begin
						next_st.rem = 64'(rem_sh - {1'b0, st.den});
						next_st.num = {st.num[62:0], 1'b1};
					end
					else
					begin
						next_st.rem = rem_sh[63:0];
						next_st.num = {st.num[62:0], 1'b0};
					end
					next_st.div_cnt = st.div_cnt - 7'h01;
					if (st.div_cnt == 7'h01 && st.div_st == DV_RATE)
					begin
						next_st.num = {next_st.num[62:0], 1'b0} >> 1;
						next_st.den = 64'(st.fres);
						next_st.rem = 64'h0;
						next_st.div_cnt = DIV_BITS;
						next_st.div_st = DV_QUANT;
					end
					else if (st.div_cnt == 7'h01)
					begin
						dflow = 32'(next_st.num[31:0] * st.fres);
						next_st.flow = st.flow_neg ? -dflow : dflow;
						next_st.div_st = DV_IDLE;
					end
				end
				default: next_st.div_st = DV_IDLE;
			endcase
		end
		// register writes take effect at the access edge
		if (wr)
		begin
			case (paddr)
				A_CTRL: next_st.ctrl = wcc_ctrl_s'({17'h00000, pwdata[14:0]});
				A_RES:
				begin
					next_st.res = pwdata;
					next_st.ol_lim = st.cap + 32'(UNDER_STEPS * pwdata);
				end
				A_CAP:
				begin
					next_st.cap = pwdata;
					next_st.ol_lim = pwdata + 32'(UNDER_STEPS * st.res);
				end
				A_OLIM: next_st.ol_lim = pwdata;
				A_FWIN: next_st.fwin = pwdata;
				A_MWIN: next_st.mwin = pwdata;
				A_NMDLY: next_st.nm_dly = pwdata;
				A_ZTRATE: next_st.zt_rate = pwdata;
				A_PTARE: next_st.ptare = pwdata;
				A_DERIV: if (!st.ctrl.auto_deriv) next_st.deriv = pwdata;
				A_FRES: next_st.fres = pwdata;
				A_CONV: next_st.conv = pwdata;
				A_CALT:
				begin
					next_st.cal_type = wcc_cal_e'(pwdata[1:0]);
					next_st.cal_start = 1'b1;
				end
				A_ZOFF: next_st.zoff = pwdata;
				default: next_st.rdata = st.rdata;
			endcase
		end
		// read data captured in the setup cycle, presented during access
		if (rd_setup)
		begin
			case (paddr)
				A_CTRL: next_st.rdata = 32'(st.ctrl);
				A_RES: next_st.rdata = st.res;
				A_CAP: next_st.rdata = st.cap;
				A_OLIM: next_st.rdata = st.ol_lim;
				A_FWIN: next_st.rdata = st.fwin;
				A_MWIN: next_st.rdata = st.mwin;
				A_NMDLY: next_st.rdata = st.nm_dly;
				A_ZTRATE: next_st.rdata = st.zt_rate;
				A_PTARE: next_st.rdata = st.ptare;
				A_DERIV: next_st.rdata = deriv_eff;
				A_FRES: next_st.rdata = st.fres;
				A_CONV: next_st.rdata = st.conv;
				A_CALT: next_st.rdata = 32'(st.cal_type);
				A_ZOFF: next_st.rdata = st.zoff;
				A_STAT: next_st.rdata = 32'(status);
				A_GROSS: next_st.rdata = st.gross;
				A_NET: next_st.rdata = st.net;
				A_FLOW: next_st.rdata = st.flow;
				default: next_st.rdata = 32'h0;
			endcase
		end
	end
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n_int)
	begin
		if (!rst_n_int)
		begin
			st <= '0;
			st.ctrl <= CTRL_RST;
			st.res <= RES_RST;
			st.cap <= CAP_RST;
			st.ol_lim <= CAP_RST + 32'(UNDER_STEPS * RES_RST);
			st.fwin <= FWIN_RST;
			st.mwin <= MWIN_RST;
			st.nm_dly <= NMDLY_RST;
			st.zt_rate <= ZTRATE_RST;
			st.deriv <= DERIV_RST;
			st.fres <= FRES_RST;
			st.conv <= CONV_RST;
			st.cal_type <= CAL_SHEET;
			st.div_st <= DV_IDLE;
		end
		else
			st <= next_st;
	end
	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign pready = 1'b1;
	assign pslverr = psel && penable && (paddr > A_FLOW || paddr[1:0] != 2'b00);
	assign prdata = st.rdata;
	assign adc_start = st.adc_start;
	assign print_ack = st.print_ack;
	assign cal_start = st.cal_start;
	assign weights = '{gross: st.gross, net: st.net, flow: st.flow};
	assign status = '{flow_on: st.ctrl.flow_on, print_blk: st.motion && st.ctrl.motion_check,
		tare_blk: st.motion && st.ctrl.motion_check, zero_blk: st.motion,
		underload: st.under, overload: st.over, motion: st.motion};
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n_int);
	sequence s_sample;
		adc_valid && !wr;
	endsequence
	sequence s_motion_hit;
		per_end && mot_cond;
	endsequence
	chk_start_period: assert property (adc_start |-> $past(st.upd_cnt) == 16'h0 && $past(tick))
		else $error("conversion start off its period");
	chk_filter_pick: assert property (s_sample ##0 (absd < st.fwin) |=> st.gross == $past(filt_nx))
		else $error("filtered weight not used inside window");
	chk_raw_pick: assert property (s_sample ##0 (absd >= st.fwin) |=> st.gross == $past(g_clamp))
		else $error("unfiltered weight not used outside window");
	chk_motion_set: assert property (s_motion_hit |=> st.motion && st.nm_cnt == $past(st.nm_dly) * TICKS_PER_DS)
		else $error("motion not set or delay not restarted");
	chk_motion_clear: assert property ($fell(st.motion) |-> $past(st.nm_cnt) == 32'h0 && $past(tick))
		else $error("motion cleared before delay expired");
	chk_print_block: assert property (print_req && st.motion && st.ctrl.motion_check |=> !print_ack)
		else $error("print allowed during motion");
	chk_zero_block: assert property (zero_req && st.motion && !wr && !per_end |=> $stable(st.zoff))
		else $error("zeroing during motion");
	chk_unipolar: assert property (st.ctrl.ol_mode == OL_UNI && $stable(st.ctrl) ##1 $stable(st.ctrl)
		|-> st.over == ($past(st.gross) > $signed($past(st.ol_lim))))
		else $error("unipolar overload flag wrong");
	chk_bipolar_clamp: assert property (s_sample ##0 st.ctrl.ol_mode == OL_BI
		|=> st.gross <= $signed($past(st.ol_lim)) && st.gross >= -$signed($past(st.ol_lim)))
		else $error("bipolar weight outside limits");
	chk_limit_reset: assert property (wr && paddr == A_RES |=> st.ol_lim == st.cap + UNDER_STEPS * st.res)
		else $error("overload limit not reset");
	chk_deriv_ro: assert property (wr && paddr == A_DERIV && st.ctrl.auto_deriv |=> $stable(st.deriv))
		else $error("derivation time written in auto mode");
	chk_flow_off: assert property (!st.ctrl.flow_on ##1 !st.ctrl.flow_on |-> $stable(st.flow))
		else $error("flow changed while disabled");
endmodule : wcc_conditioner
`default_nettype wire

// ===== tb/wcc_adc_model.sv
// converter model: answers each conversion request or kick with one sample; requests that arrive while busy are ignored
`timescale 1ns/1ps
`default_nettype none
module wcc_adc_model (
	input wire logic mclk,
	input wire logic adc_start,
	input wire logic kick,
	input wire logic [3:0] lag,
	input wire logic signed [31:0] level,
	output logic adc_valid = 1'b0,
	output logic signed [31:0] adc_data = 32'sh0
);
	logic [4:0] cnt = 5'h00;
	logic busy = 1'b0;
	// wait out the conversion time, then strobe the sample for one cycle
	always_ff @(posedge mclk)
	begin
		adc_valid <= 1'b0;
		adc_data <= ~adc_data; // no stale sample may pass for a fresh one
		if ((adc_start || kick) && !busy)
		begin
			busy <= 1'b1;
			cnt <= {1'b0, lag};
		end
		else if (busy && cnt == 5'h00)
		begin
			busy <= 1'b0;
			adc_valid <= 1'b1;
			adc_data <= level;
		end
		else if (busy)
			cnt <= cnt - 5'h01;
	end
endmodule : wcc_adc_model
`default_nettype wire

// ===== tb/tb_weight_channel_conditioner.sv
// self-checking bench for the weight channel conditioner
`timescale 1ns/1ps
`default_nettype none
module tb_weight_channel_conditioner import wcc_pkg::*;;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, kick = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic pready, pslverr, er, adc_valid, adc_start, print_ack, cal_start;
	logic signed [31:0] adc_data, level = 32'sh0;
	logic [3:0] lag = 4'h0;
	logic [2:0] rq = 3'h0;
	wcc_weights_s weights;
	wcc_status_s status;
	wcc_ctrl_s c = CTRL_RST;
	int mismatches = 0, tests_run = 0;
	logic [7:0] ra [10] = '{A_CTRL, A_RES, A_CAP, A_OLIM, A_FWIN, A_MWIN, A_NMDLY, A_DERIV,
		A_FRES, A_CONV};
	logic [31:0] rv [10] = '{32'(CTRL_RST), 32'h0000000A, 32'h0000C350, 32'h0000C3AA,
		32'h00000064, 32'h0000000A, 32'h0000000A, 32'h00000064, 32'h00000014, 32'h0009CE81};
	wcc_ol_e om [8] = '{OL_OFF, OL_UNI, OL_UNI, OL_UNI, OL_UNI, OL_BI, OL_BI, OL_BI};
	logic [31:0] sv [8] = '{32'h0000EA60, 32'h0000C3AB, 32'h0000C3AA, 32'hFFFFFFA5,
		32'hFFFFFFA6, 32'h0000EA60, 32'hFFFF15A0, 32'h0000C3A9};
	logic [31:0] gv [8] = '{32'h0000EA60, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000C3AA,
		32'hFFFF3C56, 32'h0000C3A9};
	logic [1:0] fv [8] = '{2'h0, 2'h2, 2'h0, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0};
	wcc_tare_e tm [3] = '{TM_AUTO, TM_PRESET, TM_SUM};
	logic [31:0] nv [3] = '{32'h00000000, 32'h000000C8, 32'hFFFFFED4};

	wcc_conditioner u_wcc_conditioner (.mclk(mclk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .adc_valid(adc_valid), .adc_data(adc_data),
		.adc_start(adc_start), .zero_req(rq[0]), .tare_req(rq[1]), .print_req(rq[2]),
		.print_ack(print_ack), .cal_start(cal_start), .weights(weights), .status(status));
	wcc_adc_model u_wcc_adc_model (.mclk(mclk), .adc_start(adc_start), .kick(kick),
		.lag(lag), .level(level), .adc_valid(adc_valid), .adc_data(adc_data));

	// free-running 100 MHz clock
	initial
	begin
		forever #5 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// one transfer; request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge mclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
		begin
			mismatches++;
			test_done();
		end
	endtask : apb

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		chk($sformatf("reg_%h", a), rd, e);
	endtask : rchk

	// one converter sample, prompt and slow answers in turn; returns once net is settled
	task automatic samp(input logic [31:0] v);
		int n;
		n = 0;
		@(posedge mclk);
		level <= v;
		kick <= 1'b1;
		lag <= lag ^ 4'h5;
		@(posedge mclk);
		kick <= 1'b0;
		while (adc_valid !== 1'b1 && n < 40)
		begin
			n++;
			@(posedge mclk);
		end
		if (n >= 40)
		begin
			mismatches++;
			test_done();
		end
		repeat (3) @(posedge mclk);
		#1;
	endtask : samp

	task automatic fire(input logic [2:0] m);
		@(posedge mclk);
		rq <= m;
		@(posedge mclk);
		rq <= 3'h0;
		#1;
	endtask : fire

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		for (int i = 0; i < 10; i++)
			rchk(ra[i], rv[i]);
		chk("status", 32'(status), 32'h00000040);
		apb(1'b1, 8'h48, 32'h00000001);
		chk("wr_err", 32'(er), 32'h1);
		apb(1'b0, 8'h06, 32'h00000000);
		chk("rd_err", {rd[30:0], er}, 32'h1);
		$display("test registers done");
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, A_CALT, 32'((i + 2) % 3));
			#1;
			chk("cal_start", 32'(cal_start), 32'h1);
		end
		apb(1'b1, A_FWIN, 32'h00000000);
		samp(32'h000004D2);
		chk("raw", weights.gross, 32'h000004D2);
		for (int i = 0; i < 8; i++)
		begin
			c.ol_mode = om[i];
			apb(1'b1, A_CTRL, 32'(c));
			samp(sv[i]);
			if (om[i] != OL_UNI)
				chk("gross", weights.gross, gv[i]);
			chk("flags", 32'({status.overload, status.underload}), 32'(fv[i]));
		end
		apb(1'b1, A_CAP, 32'h000003E8);
		rchk(A_OLIM, 32'h00000442);
		apb(1'b1, A_RES, 32'h00000014);
		rchk(A_OLIM, 32'h0000049C);
		$display("test limits done");
		c.ol_mode = OL_OFF;
		c.motion_check = 1'b1;
		apb(1'b1, A_CTRL, 32'(c));
		samp(32'h000002BC);
		fire(3'h1);
		rchk(A_ZOFF, 32'h000002BC);
		apb(1'b1, A_ZOFF, 32'h000000C8);
		samp(32'h000002BC);
		chk("zeroed", weights.gross, 32'h000001F4);
		fire(3'h2);
		apb(1'b1, A_PTARE, 32'h0000012C);
		for (int i = 0; i < 3; i++)
		begin
			c.tare_mode = tm[i];
			apb(1'b1, A_CTRL, 32'(c));
			samp(32'h000002BC);
			chk("net", weights.net, nv[i]);
		end
		fire(3'h4);
		chk("print_ack", 32'(print_ack), 32'h1);
		$display("test zero tare print done");
		apb(1'b1, A_DERIV, 32'h00000005);
		rchk(A_DERIV, 32'h00000064);
		c.auto_deriv = 1'b0;
		c.flow_on = 1'b0;
		apb(1'b1, A_CTRL, 32'(c));
		apb(1'b1, A_DERIV, 32'h00000005);
		rchk(A_DERIV, 32'h00000005);
		chk("flow_on", 32'(status.flow_on), 32'h0);
		apb(1'b1, A_ZOFF, 32'h00000000);
		apb(1'b1, A_FWIN, 32'h00000064);
		// the filter starts far above after the overload excursions; let it settle
		for (int i = 0; i < 60; i++)
			samp(32'h000003E8);
		samp(32'h0000041A);
		chk("filtered", 32'($signed(weights.gross) >= 1000 && $signed(weights.gross) < 1050),
			32'h1);
		apb(1'b1, A_FWIN, 32'h00000000);
		apb(1'b1, A_CALT, 32'h00000000);
		samp(32'h00010000);
		chk("conv", weights.gross, 32'h0009CE81);
		$display("test filter flow conv done");
		test_done();
	end
endmodule : tb_weight_channel_conditioner
`default_nettype wire
